// ==== verilog/vcmd_regs.vh ====
// register map, field layout and codes of the virtual command port
`ifndef VCMD_REGS_VH
`define VCMD_REGS_VH

// byte offsets on the register port
`define OFF_CAPABILITY 12'h0e00
`define OFF_SUBMISSION 12'h0e10
`define OFF_RESPONSE 12'h0e20
`define OFF_IRQ_STATUS 12'h0e30
`define OFF_IRQ_ENABLE 12'h0e38
`define OFF_IRQ_CLEAR 12'h0e40
`define OFF_FEATURE 12'h0e48

// command submission fields
`define CMD_MSB 7
`define CMD_LSB 0
`define ID_MSB 27
`define ID_LSB 8
`define ID_WIDTH 20

// command codes
`define CMD_NULL 8'h00
`define CMD_ALLOC 8'h01
`define CMD_FREE 8'h02

// command response fields
`define RSP_IP_BIT 0
`define SC_MSB 2
`define SC_LSB 1

// status codes
`define SC_OK 2'h0
`define SC_UNDEF 2'h1
`define SC_NO_ID 2'h2

// feature register: bit 0 command support, bit 1 identifier support
`define FEAT_VCS_BIT 0
`define FEAT_PASID_BIT 1
`define FEAT_RESET 2'h3

// interrupt event bits
`define EV_DONE 0
`define EV_ERROR 1
`define EV_DROP 2
`define EV_COUNT 3

// reset values
`define SUB_RESET 64'h0000_0000_0000_0000
`define RSP_RESET 64'h0000_0000_0000_0000
`define RSP_START 64'h0000_0000_0000_0001

`endif

// ==== verilog/id_bitmap_mem.v ====
// word memory holding the allocation bitmap of identifiers
`timescale 1ns/1ps
`default_nettype none

module id_bitmap_mem #(
   parameter WORD_BITS = 32,
   parameter WORD_COUNT = 8,
   parameter IDX_W = 3
) (
   input wire i_clock,
   input wire i_write_enable,
   input wire [IDX_W-1:0] i_write_address,
   input wire [WORD_BITS-1:0] i_write_data,
   input wire [IDX_W-1:0] i_read_address,
   output reg [WORD_BITS-1:0] o_read_data
);

   reg [WORD_BITS-1:0] words [0:WORD_COUNT-1];

   // no reset on the array; the owner sweeps it clear after reset
   always @(posedge i_clock) begin
      if (i_write_enable) begin
         words[i_write_address] <= i_write_data;
      end
      o_read_data <= words[i_read_address];
   end

endmodule

`default_nettype wire

// ==== verilog/event_irq.v ====
// sticky event status, enable mask and level interrupt
`timescale 1ns/1ps
`default_nettype none

module event_irq #(
   parameter N = 3
) (
   input wire i_clock,
   input wire i_reset,
   input wire [N-1:0] i_set,
   input wire i_enable_write,
   input wire [N-1:0] i_enable_data,
   input wire i_clear_write,
   input wire [N-1:0] i_clear_data,
   output reg [N-1:0] o_status,
   output reg [N-1:0] o_enable,
   output reg o_irq
);

   wire [N-1:0] clear_bits;

   assign clear_bits = i_clear_write ? i_clear_data : {N{1'b0}};

   // a set arriving with its clear wins, so no event is lost
   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         o_status <= {N{1'b0}};
         o_enable <= {N{1'b0}};
         o_irq <= 1'b0;
      end else begin
         o_status <= (o_status & ~clear_bits) | i_set;
         if (i_enable_write) begin
            o_enable <= i_enable_data;
         end
         o_irq <= |(o_status & o_enable); // lags the status by one cycle
      end
   end

endmodule

`default_nettype wire

// ==== verilog/virtual_command_port.v ====
// virtual command port: capability, submission and response registers
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "vcmd_regs.vh"

module virtual_command_port #(
   parameter ALLOC_IMPLEMENTED = 1,
   parameter WORD_BITS = 32,
   parameter WORD_COUNT = 8,
   parameter IDX_W = 3,
   parameter BIT_W = 5
) (
   input wire i_clock,
   input wire i_reset,
   input wire [11:0] i_address,
   input wire [63:0] i_write_data,
   input wire i_write_strobe,
   input wire i_read_strobe,
   output reg [63:0] o_read_data,
   output wire o_irq
);

   // engine states
   localparam [2:0] S_INIT = 3'h0;
   localparam [2:0] S_IDLE = 3'h1;
   localparam [2:0] S_READ = 3'h2;
   localparam [2:0] S_EVAL = 3'h3;

   // cut to the index width on purpose; WORD_COUNT is a power of two
   localparam [31:0] LAST_WORD = WORD_COUNT - 1;
   localparam [IDX_W-1:0] LAST_IDX = LAST_WORD[IDX_W-1:0];
   localparam PAD_W = `ID_WIDTH - IDX_W - BIT_W;

   // lowest clear bit of a bitmap word
   function [BIT_W-1:0] first_zero;
      input [WORD_BITS-1:0] w;
      integer k;
      begin
         first_zero = {BIT_W{1'b0}};
         for (k = WORD_BITS - 1; k >= 0; k = k - 1) begin
            if (!w[k]) begin
               first_zero = k[BIT_W-1:0];
            end
         end
      end
   endfunction

   // write strobe aimed at one register offset
   function wr_hit;
      input strobe;
      input [11:0] addr;
      input [11:0] offset;
      begin
         wr_hit = strobe & (addr == offset);
      end
   endfunction

   // command port registers read as zero without command support
   function [63:0] gate_support;
      input enabled;
      input [63:0] value;
      begin
         gate_support = enabled ? value : 64'h0000_0000_0000_0000;
      end
   endfunction

   // register state
   reg [63:0] submit_q;
   reg [63:0] rsp_q;
   reg [1:0] feature_q;
   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [IDX_W-1:0] idx_q;
   reg [IDX_W-1:0] idx_d;

   // engine outputs
   reg finish;
   reg [1:0] fin_status;
   reg [`ID_WIDTH-1:0] fin_id;
   reg mem_we;
   reg [WORD_BITS-1:0] mem_wdata;

   wire [WORD_BITS-1:0] mem_rdata;
   wire [`EV_COUNT-1:0] irq_status;
   wire [`EV_COUNT-1:0] irq_enable;
   wire [`EV_COUNT-1:0] events;

   // decoded access terms
   wire vcs_on;
   wire pasid_on;
   wire id_alloc_supported;
   wire in_progress;
   wire hit_submit;
   wire hit_feature;
   wire hit_enable;
   wire hit_clear;
   wire [63:0] rsp_final;
   wire accept_cmd;
   wire drop_cmd;
   wire [7:0] cmd_code;
   wire [`ID_WIDTH-1:0] op_id;
   wire [BIT_W-1:0] op_bit;
   wire [IDX_W-1:0] op_idx;
   wire op_in_range;
   wire [BIT_W-1:0] free_bit;
   wire word_full;
   wire [WORD_BITS-1:0] op_mask;

   assign vcs_on = feature_q[`FEAT_VCS_BIT];
   assign pasid_on = feature_q[`FEAT_PASID_BIT];

   // allocation is only advertised where identifiers exist at all
   assign id_alloc_supported = (ALLOC_IMPLEMENTED != 0) & pasid_on;

   assign in_progress = rsp_q[`RSP_IP_BIT];

   // one decode per writable register
   assign hit_submit = wr_hit(i_write_strobe, i_address, `OFF_SUBMISSION);
   assign hit_feature = wr_hit(i_write_strobe, i_address, `OFF_FEATURE);
   assign hit_enable = wr_hit(i_write_strobe, i_address, `OFF_IRQ_ENABLE);
   assign hit_clear = wr_hit(i_write_strobe, i_address, `OFF_IRQ_CLEAR);

   // a write is taken only when supported and nothing is running
   assign accept_cmd = hit_submit & vcs_on & ~in_progress;
   assign drop_cmd = hit_submit & vcs_on & in_progress;

   // fields of the latched command
   assign cmd_code = submit_q[`CMD_MSB:`CMD_LSB];
   assign op_id = submit_q[`ID_MSB:`ID_LSB];
   assign op_bit = op_id[BIT_W-1:0];
   assign op_idx = op_id[BIT_W +: IDX_W];
   assign op_in_range = (op_id >> (IDX_W + BIT_W)) == {`ID_WIDTH{1'b0}};
   assign op_mask = {{(WORD_BITS-1){1'b0}}, 1'b1} << op_bit;

   // bitmap word search
   assign free_bit = first_zero(mem_rdata);
   assign word_full = &mem_rdata;

   // finished response: spare bits zero, in-progress clear
   assign rsp_final = {36'h0_0000_0000, fin_id, 5'h00, fin_status, 1'b0};

   // submission register: stored whole on each accepted write
   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         submit_q <= `SUB_RESET;
      end else if (accept_cmd) begin
         submit_q <= i_write_data;
      end
   end

   // feature register; changing it mid-command is not guarded
   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         feature_q <= `FEAT_RESET;
      end else if (hit_feature) begin
         feature_q <= i_write_data[1:0];
      end
   end

   // response register: cleared with in-progress set on accept,
   // then written whole in the finishing cycle
   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         rsp_q <= `RSP_RESET;
      end else if (accept_cmd) begin
         rsp_q <= `RSP_START;
      end else if (finish) begin
         rsp_q <= rsp_final;
      end
   end

   // engine state and word index
   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         state_q <= S_INIT;
         idx_q <= {IDX_W{1'b0}};
      end else begin
         state_q <= state_d;
         idx_q <= idx_d;
      end
   end

   // engine: init sweep, decode, bitmap read and evaluate
   always @* begin
      state_d = state_q;
      idx_d = idx_q;
      finish = 1'b0;
      fin_status = `SC_OK;
      fin_id = {`ID_WIDTH{1'b0}};
      mem_we = 1'b0;
      mem_wdata = {WORD_BITS{1'b0}};
      case (state_q)
         S_INIT: begin
            // every identifier starts free; a command accepted now waits
            mem_we = 1'b1;
            if (idx_q == LAST_IDX) begin
               idx_d = {IDX_W{1'b0}};
               state_d = S_IDLE;
            end else begin
               idx_d = idx_q + 1'b1;
            end
         end
         S_IDLE: begin
            if (in_progress) begin
               if (cmd_code == `CMD_NULL) begin
                  finish = 1'b1;
               end else if (cmd_code == `CMD_ALLOC && id_alloc_supported) begin
                  idx_d = {IDX_W{1'b0}};
                  state_d = S_READ;
               end else if (cmd_code == `CMD_FREE && id_alloc_supported) begin
                  if (op_in_range) begin
                     idx_d = op_idx;
                     state_d = S_READ;
                  end else begin
                     finish = 1'b1;
                     fin_status = `SC_NO_ID;
                  end
               end else begin
                  // reserved codes, or commands not advertised
                  finish = 1'b1;
                  fin_status = `SC_UNDEF;
               end
            end
         end
         S_READ: begin
            // read data registered, ready in the next state
            state_d = S_EVAL;
         end
         S_EVAL: begin
            if (cmd_code == `CMD_ALLOC) begin
               if (!word_full) begin
                  mem_we = 1'b1;
                  mem_wdata = mem_rdata | ({{(WORD_BITS-1){1'b0}}, 1'b1} << free_bit);
                  finish = 1'b1;
                  fin_id = {{PAD_W{1'b0}}, idx_q, free_bit};
                  state_d = S_IDLE;
               end else if (idx_q == LAST_IDX) begin
                  finish = 1'b1;
                  fin_status = `SC_NO_ID;
                  state_d = S_IDLE;
               end else begin
                  // word full: try the next one
                  idx_d = idx_q + 1'b1;
                  state_d = S_READ;
               end
            end else begin
               // free: the identifier must be currently allocated
               finish = 1'b1;
               state_d = S_IDLE;
               if ((mem_rdata & op_mask) != {WORD_BITS{1'b0}}) begin
                  mem_we = 1'b1;
                  mem_wdata = mem_rdata & ~op_mask;
               end else begin
                  fin_status = `SC_NO_ID;
               end
            end
         end
         default: begin
            state_d = S_INIT;
            idx_d = {IDX_W{1'b0}};
         end
      endcase
   end

   // bitmap storage; read and write both use the word index
   id_bitmap_mem #(
      .WORD_BITS(WORD_BITS),
      .WORD_COUNT(WORD_COUNT),
      .IDX_W(IDX_W)
   ) u_bitmap (
      .i_clock(i_clock),
      .i_write_enable(mem_we),
      .i_write_address(idx_q),
      .i_write_data(mem_wdata),
      .i_read_address(idx_q),
      .o_read_data(mem_rdata)
   );

   // events: completion, error completion, dropped submission
   assign events[`EV_DONE] = finish;
   assign events[`EV_ERROR] = finish & (fin_status != `SC_OK);
   assign events[`EV_DROP] = drop_cmd;

   event_irq #(
      .N(`EV_COUNT)
   ) u_irq (
      .i_clock(i_clock),
      .i_reset(i_reset),
      .i_set(events),
      .i_enable_write(hit_enable),
      .i_enable_data(i_write_data[`EV_COUNT-1:0]),
      .i_clear_write(hit_clear),
      .i_clear_data(i_write_data[`EV_COUNT-1:0]),
      .o_status(irq_status),
      .o_enable(irq_enable),
      .o_irq(o_irq)
   );

   // read data one cycle after the strobe, zero otherwise
   always @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         o_read_data <= 64'h0000_0000_0000_0000;
      end else if (!i_read_strobe) begin
         o_read_data <= 64'h0000_0000_0000_0000;
      end else begin
         case (i_address)
            `OFF_CAPABILITY: begin
               o_read_data <= gate_support(vcs_on, {63'h0, id_alloc_supported});
            end
            `OFF_SUBMISSION: begin
               o_read_data <= gate_support(vcs_on, submit_q);
            end
            `OFF_RESPONSE: begin
               o_read_data <= gate_support(vcs_on, rsp_q);
            end
            `OFF_IRQ_STATUS: begin
               o_read_data <= {{(64-`EV_COUNT){1'b0}}, irq_status};
            end
            `OFF_IRQ_ENABLE: begin
               o_read_data <= {{(64-`EV_COUNT){1'b0}}, irq_enable};
            end
            `OFF_FEATURE: begin
               o_read_data <= {62'h0, feature_q};
            end
            default: begin
               // unmapped and write-only offsets read zero
               o_read_data <= 64'h0000_0000_0000_0000;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// ==== sim/virtual_command_port_chk.sv ====
// assertion checker on the ports of the virtual command port
`timescale 1ns/1ps
`default_nettype none
module virtual_command_port_chk #(
   parameter ALLOC_IMPLEMENTED = 1
) (
   input wire logic i_clock,
   input wire logic i_reset,
   input wire logic [11:0] i_address,
   input wire logic [63:0] i_write_data,
   input wire logic i_write_strobe,
   input wire logic i_read_strobe,
   input wire logic [63:0] o_read_data,
   input wire logic o_irq
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_reset);
   logic [1:0] feat_q;
   logic [2:0] en_q;
   logic rd_map;
   logic rd_rsp;
   logic idle_q;
   logic rd_rsp_q;
   // shadows rebuilt from bus writes only, so the design is never trusted
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         feat_q <= 2'h3;
         en_q <= 3'h0;
      end else if (i_write_strobe) begin
         if (i_address == 12'he48) feat_q <= i_write_data[1:0];
         if (i_address == 12'he38) en_q <= i_write_data[2:0];
      end
   end
   // the clear register is write-only, so it counts as unreadable
   assign rd_map = i_address inside {12'he00, 12'he10, 12'he20, 12'he30, 12'he38, 12'he48};
   assign rd_rsp = i_read_strobe && i_address == 12'he20;
   // a write counts as a new command only after reset or once a read showed the port idle
   always_ff @(posedge i_clock or posedge i_reset) begin
      if (i_reset) begin
         idle_q <= 1'b1;
         rd_rsp_q <= 1'b0;
      end else begin
         rd_rsp_q <= rd_rsp;
         if (i_write_strobe && i_address == 12'he10 && feat_q[0]) begin
            idle_q <= 1'b0;
         end else if (rd_rsp_q && feat_q[0] && !o_read_data[0]) begin
            idle_q <= 1'b1;
         end
      end
   end
   property p_rd_idle;
      !i_read_strobe |=> o_read_data == 64'h0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
   property p_unmapped;
      i_read_strobe && !rd_map |=> o_read_data == 64'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_cap;
      i_read_strobe && i_address == 12'he00 |=>
         o_read_data == {63'h0, feat_q[0] & feat_q[1] & (ALLOC_IMPLEMENTED != 0)};
   endproperty
   a_cap: assert property (p_cap) else $error("capability value wrong");
   property p_off_zero;
      i_read_strobe && !feat_q[0] && i_address inside {12'he00, 12'he10, 12'he20}
         |=> o_read_data == 64'h0;
   endproperty
   a_off_zero: assert property (p_off_zero) else $error("support off but not zero");
   property p_rsp_fmt;
      rd_rsp |=> o_read_data[63:28] == 36'h0 && o_read_data[7:3] == 5'h0;
   endproperty
   a_rsp_fmt: assert property (p_rsp_fmt) else $error("response spare bits set");
   property p_ip_clean;
      rd_rsp ##1 o_read_data[0] |-> o_read_data == 64'h1;
   endproperty
   a_ip_clean: assert property (p_ip_clean) else $error("partial response seen");
   property p_start;
      i_write_strobe && i_address == 12'he10 && feat_q[0] && idle_q ##1 rd_rsp
         |=> o_read_data == 64'h1;
   endproperty
   a_start: assert property (p_start) else $error("submit did not start");
   property p_irq_mask;
      i_write_strobe && i_address == 12'he38 && i_write_data[2:0] == 3'h0 |=> ##1 !o_irq;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt still high");
   c_done: cover property (rd_rsp ##1 o_read_data[0] == 1'b0);
   c_irq: cover property (o_irq);
   c_busy: cover property (rd_rsp ##1 o_read_data == 64'h1);
endmodule
`default_nettype wire

// ==== sim/virtual_command_port_bench.sv ====
// self-checking bench of the virtual command port
`timescale 1ns/1ps
`default_nettype none
module virtual_command_port_bench;
   logic i_clock = 1'b0;
   logic i_reset = 1'b1;
   logic [11:0] i_address = 12'h000;
   logic [63:0] i_write_data = 64'h0;
   logic i_write_strobe = 1'b0;
   logic i_read_strobe = 1'b0;
   logic [63:0] o_read_data;
   logic o_irq;
   int n_fail = 0;
   int tests_run = 0;
   virtual_command_port DUT (.i_clock(i_clock), .i_reset(i_reset), .i_address(i_address),
      .i_write_data(i_write_data), .i_write_strobe(i_write_strobe),
      .i_read_strobe(i_read_strobe), .o_read_data(o_read_data), .o_irq(o_irq));
   // 100 MHz system clock
   initial begin
      forever #5 i_clock = ~i_clock;
   end
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // each access leaves one idle cycle, so no strobe is set twice at an edge
   task automatic wr(input logic [11:0] a, input logic [63:0] d);
      @(posedge i_clock);
      i_address <= a;
      i_write_data <= d;
      i_write_strobe <= 1'b1;
      @(posedge i_clock);
      i_write_strobe <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, output logic [63:0] d);
      @(posedge i_clock);
      i_address <= a;
      i_read_strobe <= 1'b1;
      @(posedge i_clock);
      i_read_strobe <= 1'b0;
      #1 d = o_read_data;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [63:0] exp);
      logic [63:0] r;
      rd(a, r);
      chk(r, exp);
   endtask
   // write then read the response with no gap, catching the in-progress state
   task automatic submit(input logic [63:0] d, input logic [63:0] e1);
      @(posedge i_clock);
      i_address <= 12'he10;
      i_write_data <= d;
      i_write_strobe <= 1'b1;
      @(posedge i_clock);
      i_write_strobe <= 1'b0;
      i_address <= 12'he20;
      i_read_strobe <= 1'b1;
      @(posedge i_clock);
      i_read_strobe <= 1'b0;
      #1 chk(o_read_data, e1);
   endtask
   task automatic done(input logic [63:0] exp);
      logic [63:0] r;
      r = 64'h1;
      for (int k = 0; k < 40 && r[0] !== 1'b0; k++) rd(12'he20, r);
      chk(r, exp);
   endtask
   task automatic cmd(input logic [63:0] d, input logic [63:0] exp);
      submit(d, 64'h1);
      done(exp);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // watchdog well beyond the longest expected run
   initial begin
      #600000;
      n_fail++;
      end_sim();
   end
   initial begin
      repeat (10) @(posedge i_clock);
      i_reset <= 1'b0;
      rdc(12'he00, 64'h1);
      rdc(12'he10, 64'h0);
      rdc(12'he20, 64'h0);
      rdc(12'he48, 64'h3);
      rdc(12'he08, 64'h0);
      wr(12'he00, 64'h0);
      rdc(12'he00, 64'h1);
      wr(12'he38, 64'h7);
      cmd(64'hffff_ffff_ffff_ff01, 64'h0);
      rdc(12'he10, 64'hffff_ffff_ffff_ff01);
      cmd(64'h1, 64'h100);
      cmd(64'h102, 64'h0);
      cmd(64'h102, 64'h4);
      cmd(64'h1, 64'h100);
      cmd(64'h0, 64'h0);
      cmd(64'h3, 64'h2);
      cmd(64'h80, 64'h2);
      cmd(64'hff, 64'h2);
      // a second command while busy must leave the first untouched
      submit(64'h1, 64'h1);
      wr(12'he10, 64'h202);
      done(64'h200);
      rdc(12'he10, 64'h1);
      rdc(12'he30, 64'h7);
      chk({63'h0, o_irq}, 64'h1);
      wr(12'he40, 64'h7);
      rdc(12'he30, 64'h0);
      chk({63'h0, o_irq}, 64'h0);
      wr(12'he38, 64'h0);
      cmd(64'h0, 64'h0);
      rdc(12'he30, 64'h1);
      chk({63'h0, o_irq}, 64'h0);
      wr(12'he38, 64'h1);
      rdc(12'he40, 64'h0);
      chk({63'h0, o_irq}, 64'h1);
      wr(12'he40, 64'h7);
      // command support off: registers read zero and ignore writes; then identifier support off: alloc and free undefined
      wr(12'he48, 64'h2);
      rdc(12'he00, 64'h0);
      submit(64'h1, 64'h0);
      wr(12'he48, 64'h3);
      rdc(12'he10, 64'h0);
      wr(12'he48, 64'h1);
      rdc(12'he00, 64'h0);
      cmd(64'h1, 64'h2);
      cmd(64'h2, 64'h2);
      wr(12'he48, 64'h3);
      // drain the identifier pool up to its last entry
      for (int i = 3; i < 256; i++) cmd(64'h1, 64'(i) << 8);
      cmd(64'h1, 64'h4);
      cmd(64'h1_0002, 64'h4);
      cmd(64'habc0_0000_0000_ff02, 64'h0);
      cmd(64'h1, 64'hff00);
      end_sim();
   end
endmodule
bind virtual_command_port virtual_command_port_chk #(.ALLOC_IMPLEMENTED(ALLOC_IMPLEMENTED)) chk_i
   (.i_clock(i_clock), .i_reset(i_reset), .i_address(i_address), .i_write_data(i_write_data),
   .i_write_strobe(i_write_strobe), .i_read_strobe(i_read_strobe),
   .o_read_data(o_read_data), .o_irq(o_irq));
`default_nettype wire
